// File: bus_ctrl_model.sv
// Controller model issuing cyclic register reads and writes.
// Assumes the device answers one cycle after each strobe.
module bus_ctrl_model #(
    parameter int unsigned GAP = 2
) (
    input wire logic clk_sys_i,
    input wire logic [15:0] reg_rdata_i,
    input wire logic reg_rvalid_i,
    input wire logic reg_wr_ack_i,
    output logic reg_rd_o,
    output logic reg_wr_o,
    output logic [7:0] reg_addr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_rd_o = 1'b0;
        reg_wr_o = 1'b0;
        reg_addr_o = 8'h00;
    end
    task automatic rd(input logic [7:0] a, output logic [15:0] d,
        output logic v);
        @(posedge clk_sys_i);
        #1;
        reg_rd_o = 1'b1;
        reg_addr_o = a;
        @(posedge clk_sys_i);
        #1;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a; // Released address is not left at its value
        v = reg_rvalid_i;
        d = reg_rdata_i;
        repeat (GAP) @(posedge clk_sys_i);
    endtask
    task automatic wr(input logic [7:0] a, output logic k);
        @(posedge clk_sys_i);
        #1;
        reg_wr_o = 1'b1;
        reg_addr_o = a;
        @(posedge clk_sys_i);
        #1;
        reg_wr_o = 1'b0;
        reg_addr_o = ~a;
        k = reg_wr_ack_i;
        repeat (GAP) @(posedge clk_sys_i);
    endtask
endmodule

// File: led_pattern.sv
// Free-running LED flash pattern generator.
// Assumes one clock; the tick length is a parameter so benches can shorten it.
module led_pattern #(
    parameter int unsigned TICK_CYCLES = supply_monitor_pkg::LED_TICK_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    output logic single_o,
    output logic double_o,
    output logic blink_o
);
    localparam int unsigned DIV_W = $clog2(TICK_CYCLES + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic [4:0] tick;
        logic single;
        logic dbl;
        logic blink;
    } pat_state_s;

    pat_state_s state_reg;
    pat_state_s state_next;

    always_comb begin
        state_next = state_reg;
        if (state_reg.div == DIV_LAST) begin
            state_next.div = '0;
            if (state_reg.tick == supply_monitor_pkg::LED_FRAME_TICKS - 5'h01)
                state_next.tick = '0;
            else
                state_next.tick = state_reg.tick + 5'h01;
        end else begin
            state_next.div = state_reg.div + DIV_W'(1);
        end
        state_next.single =
            state_reg.tick < supply_monitor_pkg::FLASH_ON_TICKS;
        state_next.dbl = state_next.single ||
            (state_reg.tick >= supply_monitor_pkg::FLASH2_START &&
             state_reg.tick < supply_monitor_pkg::FLASH2_END);
        state_next.blink =
            ~state_reg.tick[supply_monitor_pkg::BLINK_BIT];
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign single_o = state_reg.single;
    assign double_o = state_reg.dbl;
    assign blink_o = state_reg.blink;
endmodule

// File: supply_monitor_chk.sv
// Port checker for the supply monitor registers and LEDs.
// Assumes it is bound to every supply_monitor_status instance.
module supply_monitor_chk #(
    parameter int unsigned MEAS_W = 16
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic model_bus_ctrl_i,
    input wire logic power_good_i,
    input wire logic [1:0] op_state_i,
    input wire logic fw_invalid_i,
    input wire logic [MEAS_W-1:0] bus_current_i,
    input wire logic [MEAS_W-1:0] bus_voltage_i,
    input wire logic [MEAS_W-1:0] io_voltage_i,
    input wire logic reg_rd_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic reg_wr_ack_o,
    input wire logic [3:0] analog_slots_o,
    input wire logic led_run_green_o,
    input wire logic led_error_red_o,
    input wire logic led_overload_red_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Flags lag inputs by two edges, so history is trusted after three
    logic [1:0] up_reg;
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) up_reg <= 2'h0;
        else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
    end
    wire logic up = (up_reg == 2'h3);
    wire logic st_rd = reg_rd_i && (reg_addr_i == 8'h00);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    chk_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read without answer");
    chk_no_stray_valid: assert property (!reg_rd_i |=>
        !reg_rvalid_o)
        else $error("answer without read");
    chk_write_ack: assert property (reg_wr_i && !reg_rd_i |=>
        reg_wr_ack_o)
        else $error("write not acknowledged");
    chk_reserved_zero: assert property (st_rd |=>
        reg_rdata_o[15:3] == 13'h0000 && !reg_rdata_o[1])
        else $error("reserved status bit set");
    chk_bus_warn: assert property (up && st_rd |=>
        reg_rdata_o[0] == ($past(bus_current_i, 2) > 16'h0017 ||
        $past(bus_voltage_i, 2) < 16'h002f))
        else $error("bus warning bit wrong");
    chk_io_under: assert property (up && st_rd |=>
        reg_rdata_o[2] == ($past(io_voltage_i, 2) < 16'h00cc))
        else $error("io undervoltage bit wrong");
    chk_std_clip: assert property (
        reg_rd_i && reg_addr_i == 8'h02 && !model_bus_ctrl_i |=>
        reg_rdata_o == ($past(bus_current_i) > 16'h00ff ? 16'h00ff :
        $past(bus_current_i)))
        else $error("standard current reading wrong");
    chk_wide_volt: assert property (
        reg_rd_i && reg_addr_i == 8'h04 && model_bus_ctrl_i |=>
        reg_rdata_o == $past(bus_voltage_i))
        else $error("wide voltage reading wrong");
    chk_slot_count: assert property (model_bus_ctrl_i |=>
        analog_slots_o == 4'h1)
        else $error("slot count wrong");
    chk_overload_led: assert property (up |-> led_overload_red_o ==
        ($past(power_good_i) && $past(bus_current_i, 2) > 16'h0017))
        else $error("overload lamp wrong");
    chk_fw_red: assert property (up && $past(power_good_i) &&
        $past(fw_invalid_i) |-> led_error_red_o)
        else $error("firmware lamp wrong");
    chk_green_run: assert property (up && $past(power_good_i) &&
        !$past(fw_invalid_i) && $past(op_state_i) == 2'h2 |-> led_run_green_o)
        else $error("run lamp wrong");
    chk_green_dark: assert property (!power_good_i |=>
        !led_run_green_o)
        else $error("lamp lit without power");
    cover property (reg_rd_i && model_bus_ctrl_i);
    cover property (led_error_red_o && led_run_green_o);
    cover property (reg_wr_i ##1 reg_wr_ack_o);
endmodule
bind supply_monitor_status supply_monitor_chk #(.MEAS_W(MEAS_W)) u_chk (.*);

// File: supply_monitor_pkg.sv
// Constants, register numbers, thresholds and LED timing of the supply monitor.
// Assumes measurements arrive already scaled to 0.1 A and 0.1 V steps.
// Operation
// - Status bit 0 is set while bus current is above 2.3 A or bus voltage is below 4.7 V, else clear.
// - Status bit 2 is set while the I/O supply is below 20.4 V and clear while it is above.
// - The current reading is an unsigned count of 0.1 A steps.
// - The voltage reading is an unsigned count of 0.1 V steps.
// - In the standard model status, current and voltage sit at numbers 0, 2 and 4 as 8-bit values.
// - In the bus-controller model the same three sit at byte offsets 0, 2 and 4 as 16-bit values.
// - In the bus-controller model the module takes exactly one analog slot.
// - Green is off without power, single-flashes in reset, blinks in startup config, is on in run.
// - Red error double-flashes on bus overload, low I/O supply or low bus feed, else stays off.
// - With invalid firmware red error is steady on and green single-flashes.
// - Red overload is off while the bus supply is in limits and steadily on when overloaded.
package supply_monitor_pkg;

    localparam int unsigned CLK_FREQ_HZ = 200_000_000;

    // Register numbers, equal to byte offsets in both models
    localparam logic [7:0] REG_STATUS_NUM = 8'h00;
    localparam logic [7:0] REG_CURRENT_NUM = 8'h02;
    localparam logic [7:0] REG_VOLTAGE_NUM = 8'h04;
    localparam int unsigned STD_REG_W = 8;
    localparam int unsigned BC_REG_W = 16;
    localparam logic [15:0] RDATA_RST = 16'h0000;

    // Status field positions
    localparam int unsigned BIT_BUS_WARN = 0;
    localparam int unsigned BIT_IO_UNDER = 2;

    // Scaling and thresholds
    localparam int unsigned MEAS_W = 16;
    localparam int unsigned CURRENT_LSB_MA = 100;
    localparam int unsigned VOLTAGE_LSB_MV = 100;
    localparam int unsigned BUS_OVERCURRENT_MA = 2300;
    localparam int unsigned BUS_UNDERVOLT_MV = 4700;
    localparam int unsigned IO_UNDERVOLT_MV = 20400;
    localparam logic [15:0] BUS_OVERCURRENT_CNT =
        16'(BUS_OVERCURRENT_MA / CURRENT_LSB_MA);
    localparam logic [15:0] BUS_UNDERVOLT_CNT =
        16'(BUS_UNDERVOLT_MV / VOLTAGE_LSB_MV);
    localparam logic [15:0] IO_UNDERVOLT_CNT =
        16'(IO_UNDERVOLT_MV / VOLTAGE_LSB_MV);

    // Controller side timing, kept for reference only; the bench does not use it
    localparam int unsigned MIN_CYCLE_US = 100;
    localparam int unsigned MIN_IO_UPDATE_US = 2000;

    localparam logic [3:0] ANALOG_SLOTS = 4'h1;

    // Operating state codes on op_state_i
    localparam logic [1:0] OPS_RESET = 2'h0;
    localparam logic [1:0] OPS_STARTUP_CONFIG = 2'h1;
    localparam logic [1:0] OPS_RUN = 2'h2;

    // LED timing: one tick, a frame of ticks, flash windows
    localparam int unsigned LED_TICK_US = 50_000;
    localparam int unsigned LED_TICK_CYCLES =
        (CLK_FREQ_HZ / 1_000_000) * LED_TICK_US;
    localparam logic [4:0] LED_FRAME_TICKS = 5'h18;
    localparam logic [4:0] FLASH_ON_TICKS = 5'h04;
    localparam logic [4:0] FLASH2_START = 5'h08;
    localparam logic [4:0] FLASH2_END = 5'h0c;
    localparam int unsigned BLINK_BIT = 2;

    typedef enum logic [2:0] {
        PAT_OFF,
        PAT_ON,
        PAT_SINGLE,
        PAT_DOUBLE,
        PAT_BLINK
    } led_pattern_e;

endpackage

// File: supply_monitor_status.sv
// Status registers and status LEDs of the 24 V supply module.
// Assumes a controller issues one-cycle read strobes with a register number.
module supply_monitor_status #(
    parameter int unsigned MEAS_W = supply_monitor_pkg::MEAS_W,
    parameter int unsigned TICK_CYCLES = supply_monitor_pkg::LED_TICK_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic model_bus_ctrl_i,
    input wire logic power_good_i,
    input wire logic [1:0] op_state_i,
    input wire logic fw_invalid_i,
    input wire logic feed_undervoltage_i,
    input wire logic [MEAS_W-1:0] bus_current_i,
    input wire logic [MEAS_W-1:0] bus_voltage_i,
    input wire logic [MEAS_W-1:0] io_voltage_i,
    input wire logic reg_rd_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic reg_wr_ack_o,
    output logic [3:0] analog_slots_o,
    output logic led_run_green_o,
    output logic led_error_red_o,
    output logic led_overload_red_o
);
    typedef struct packed {
        logic [15:0] rdata;
        logic rvalid;
        logic wr_ack;
        logic [3:0] slots;
        logic green;
        logic red_err;
        logic red_ovl;
    } mon_state_s;

    mon_state_s state_reg;
    mon_state_s state_next;

    logic bus_warn;
    logic overload;
    logic io_under;
    logic pat_single;
    logic pat_double;
    logic pat_blink;

    supply_threshold #(
        .MEAS_W(MEAS_W)
    ) u_threshold (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .bus_current_i(bus_current_i),
        .bus_voltage_i(bus_voltage_i),
        .io_voltage_i(io_voltage_i),
        .bus_warn_o(bus_warn),
        .overload_o(overload),
        .io_under_o(io_under)
    );

    led_pattern #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_pattern (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .single_o(pat_single),
        .double_o(pat_double),
        .blink_o(pat_blink)
    );

    // Standard model clips readings that exceed one byte
    function automatic logic [15:0] fit_reading(
        input logic [MEAS_W-1:0] value,
        input logic wide
    );
        logic [15:0] full;
        full = 16'(value);
        if (wide)
            fit_reading = full;
        else if (full > 16'h00ff)
            fit_reading = 16'h00ff;
        else
            fit_reading = full;
    endfunction

    function automatic logic show(
        input supply_monitor_pkg::led_pattern_e pat,
        input logic single,
        input logic dbl,
        input logic blink
    );
        case (pat)
            supply_monitor_pkg::PAT_OFF: show = 1'b0;
            supply_monitor_pkg::PAT_ON: show = 1'b1;
            supply_monitor_pkg::PAT_SINGLE: show = single;
            supply_monitor_pkg::PAT_DOUBLE: show = dbl;
            supply_monitor_pkg::PAT_BLINK: show = blink;
            default: show = 1'b0;
        endcase
    endfunction

    supply_monitor_pkg::led_pattern_e green_pat;
    supply_monitor_pkg::led_pattern_e red_err_pat;
    supply_monitor_pkg::led_pattern_e red_ovl_pat;
    logic [15:0] status_word;
    logic [15:0] read_word;

    always_comb begin
        status_word = 16'h0000;
        status_word[supply_monitor_pkg::BIT_BUS_WARN] = bus_warn;
        status_word[supply_monitor_pkg::BIT_IO_UNDER] = io_under;
    end

    // Readings are taken live at each strobe; status bits come from the registered comparators, one cycle older
    always_comb begin
        case (reg_addr_i)
            supply_monitor_pkg::REG_STATUS_NUM:
                read_word = status_word;
            supply_monitor_pkg::REG_CURRENT_NUM:
                read_word = fit_reading(bus_current_i,
                                        model_bus_ctrl_i);
            supply_monitor_pkg::REG_VOLTAGE_NUM:
                read_word = fit_reading(bus_voltage_i,
                                        model_bus_ctrl_i);
            default:
                read_word = 16'h0000;
        endcase
    end

    always_comb begin
        if (!power_good_i) begin
            green_pat = supply_monitor_pkg::PAT_OFF;
        end else if (fw_invalid_i) begin
            green_pat = supply_monitor_pkg::PAT_SINGLE;
        end else begin
            case (op_state_i)
                supply_monitor_pkg::OPS_RESET:
                    green_pat = supply_monitor_pkg::PAT_SINGLE;
                supply_monitor_pkg::OPS_STARTUP_CONFIG:
                    green_pat = supply_monitor_pkg::PAT_BLINK;
                supply_monitor_pkg::OPS_RUN:
                    green_pat = supply_monitor_pkg::PAT_ON;
                default:
                    green_pat = supply_monitor_pkg::PAT_SINGLE;
            endcase
        end
    end

    always_comb begin
        if (!power_good_i)
            red_err_pat = supply_monitor_pkg::PAT_OFF;
        else if (fw_invalid_i)
            red_err_pat = supply_monitor_pkg::PAT_ON;
        else if (overload || io_under || feed_undervoltage_i)
            red_err_pat = supply_monitor_pkg::PAT_DOUBLE;
        else
            red_err_pat = supply_monitor_pkg::PAT_OFF;
    end

    always_comb begin
        if (power_good_i && overload)
            red_ovl_pat = supply_monitor_pkg::PAT_ON;
        else
            red_ovl_pat = supply_monitor_pkg::PAT_OFF;
    end

    always_comb begin
        state_next = state_reg;
        state_next.rvalid = reg_rd_i;
        if (reg_rd_i)
            state_next.rdata = read_word;
        // Writes are acknowledged unless a read shares the cycle, and change nothing
        state_next.wr_ack = reg_wr_i && !reg_rd_i;
        state_next.slots = model_bus_ctrl_i ?
            supply_monitor_pkg::ANALOG_SLOTS : 4'h0;
        state_next.green = show(green_pat, pat_single, pat_double,
                                pat_blink);
        state_next.red_err = show(red_err_pat, pat_single, pat_double,
                                  pat_blink);
        state_next.red_ovl = show(red_ovl_pat, pat_single, pat_double,
                                  pat_blink);
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= '0;
            state_reg.rdata <= supply_monitor_pkg::RDATA_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata_o = state_reg.rdata;
    assign reg_rvalid_o = state_reg.rvalid;
    assign reg_wr_ack_o = state_reg.wr_ack;
    assign analog_slots_o = state_reg.slots;
    assign led_run_green_o = state_reg.green;
    assign led_error_red_o = state_reg.red_err;
    assign led_overload_red_o = state_reg.red_ovl;
endmodule

// File: supply_threshold.sv
// Registered warning comparators for bus current, bus voltage and I/O supply.
// Assumes inputs are counts of 0.1 A or 0.1 V, synchronous to the clock.
module supply_threshold #(
    parameter int unsigned MEAS_W = supply_monitor_pkg::MEAS_W
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic [MEAS_W-1:0] bus_current_i,
    input wire logic [MEAS_W-1:0] bus_voltage_i,
    input wire logic [MEAS_W-1:0] io_voltage_i,
    output logic bus_warn_o,
    output logic overload_o,
    output logic io_under_o
);
    typedef struct packed {
        logic overload;
        logic bus_warn;
        logic io_under;
    } cmp_state_s;

    cmp_state_s state_reg;
    cmp_state_s state_next;

    always_comb begin
        state_next.overload = bus_current_i >
            MEAS_W'(supply_monitor_pkg::BUS_OVERCURRENT_CNT);
        state_next.bus_warn = state_next.overload || bus_voltage_i <
            MEAS_W'(supply_monitor_pkg::BUS_UNDERVOLT_CNT);
        // Exactly 20.4 V counts as above the warning level
        state_next.io_under = io_voltage_i <
            MEAS_W'(supply_monitor_pkg::IO_UNDERVOLT_CNT);
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign bus_warn_o = state_reg.bus_warn;
    assign overload_o = state_reg.overload;
    assign io_under_o = state_reg.io_under;
endmodule

// File: testbench.sv
// Self-checking bench for the supply monitor status block.
// Assumes a shortened LED tick of 4 cycles: one frame is 96 cycles.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic model = 1'b0, pg = 1'b1, fw = 1'b0, feed = 1'b0;
    logic [1:0] ops = 2'h2;
    logic [15:0] cur = 16'h0000, volt = 16'h0032, io = 16'h00f0;
    logic rd, wr, rvalid, wr_ack, green, red, ovl, ack;
    logic [7:0] addr;
    logic [15:0] rdata;
    logic [3:0] slots;
    int err_count = 0;
    int cmp_count = 0;
    initial forever #2.5 clk_sys_i = ~clk_sys_i;
    supply_monitor_status #(.TICK_CYCLES(4)) DUT (.clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i), .model_bus_ctrl_i(model), .power_good_i(pg),
        .op_state_i(ops), .fw_invalid_i(fw), .feed_undervoltage_i(feed),
        .bus_current_i(cur), .bus_voltage_i(volt), .io_voltage_i(io),
        .reg_rd_i(rd), .reg_wr_i(wr), .reg_addr_i(addr),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .reg_wr_ack_o(wr_ack),
        .analog_slots_o(slots), .led_run_green_o(green),
        .led_error_red_o(red), .led_overload_red_o(ovl));
    bus_ctrl_model bus (.clk_sys_i(clk_sys_i), .reg_rdata_i(rdata),
        .reg_rvalid_i(rvalid), .reg_wr_ack_i(wr_ack), .reg_rd_o(rd),
        .reg_wr_o(wr), .reg_addr_o(addr));
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        logic v;
        bus.rd(a, d, v);
        check({15'h0000, v}, 16'h0001);
        check(d, e);
    endtask
    // Both models are read back to back after one input change
    task automatic reg_case(input logic [15:0] c, input logic [15:0] v,
        input logic [15:0] w);
        logic [15:0] st;
        @(posedge clk_sys_i);
        #1;
        cur = c;
        volt = v;
        io = w;
        st = {13'h0000, w < 16'h00cc, 1'b0, c > 16'h0017 || v < 16'h002f};
        for (int m = 0; m < 2; m++) begin
            @(posedge clk_sys_i);
            #1;
            model = m[0];
            rd_chk(8'h00, st);
            rd_chk(8'h02, m ? c : (c > 16'h00ff ? 16'h00ff : c));
            rd_chk(8'h04, m ? v : (v > 16'h00ff ? 16'h00ff : v));
        end
    endtask
    // Lit cycles over two frames tell off, single, double, blink and on
    task automatic led_case(input int p, input logic [1:0] s,
        input int f, input int u, input logic [15:0] c,
        input logic [15:0] w, input int g, input int r, input int o);
        logic [15:0] ng, nr, no;
        @(posedge clk_sys_i);
        #1;
        pg = p[0];
        ops = s;
        fw = f[0];
        feed = u[0];
        cur = c;
        io = w;
        ng = 16'h0000;
        nr = 16'h0000;
        no = 16'h0000;
        repeat (8) @(posedge clk_sys_i);
        repeat (192) begin
            @(posedge clk_sys_i);
            #1;
            ng += 16'(green);
            nr += 16'(red);
            no += 16'(ovl);
        end
        check(ng, 16'(g));
        check(nr, 16'(r));
        check(no, 16'(o));
    endtask
    initial begin
        repeat (6) @(posedge clk_sys_i);
        #1;
        resetn_i = 1'b1;
        reg_case(16'h0017, 16'h002f, 16'h00cc);
        reg_case(16'h0018, 16'h0050, 16'h00cb);
        reg_case(16'h0005, 16'h002e, 16'h00f0);
        reg_case(16'h012c, 16'h0100, 16'h0000);
        #1;
        check({12'h000, slots}, 16'h0001);
        bus.wr(8'h02, ack);
        check({15'h0000, ack}, 16'h0001);
        rd_chk(8'h02, 16'h012c);
        rd_chk(8'h06, 16'h0000);
        // Model switch kept off the edge that samples it
        #1;
        model = 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1;
        check({12'h000, slots}, 16'h0000);
        led_case(1, 2'h2, 0, 0, 16'h0010, 16'h00f0, 192, 0, 0);
        led_case(1, 2'h1, 0, 0, 16'h0010, 16'h00f0, 96, 0, 0);
        led_case(1, 2'h0, 0, 0, 16'h0010, 16'h00f0, 32, 0, 0);
        led_case(1, 2'h3, 0, 0, 16'h0010, 16'h00f0, 32, 0, 0);
        led_case(1, 2'h2, 0, 0, 16'h0010, 16'h00cb, 192, 64, 0);
        led_case(1, 2'h2, 0, 0, 16'h0018, 16'h00f0, 192, 64, 192);
        led_case(1, 2'h2, 0, 1, 16'h0010, 16'h00f0, 192, 64, 0);
        led_case(1, 2'h2, 1, 0, 16'h0010, 16'h00f0, 32, 192, 0);
        led_case(0, 2'h2, 1, 0, 16'h0018, 16'h00f0, 0, 0, 0);
        report_and_stop();
    end
    // Whole run is about two thousand cycles, so this only fires on a hang
    initial begin
        #100000;
        err_count++;
        report_and_stop();
    end
endmodule
